//--- dlim_defines.vh
`ifndef DLIM_DEFINES_VH
`define DLIM_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DLIM_OFS_RAW_NORMAL 8'h00
`define DLIM_OFS_EN_STAT_NORMAL 8'h04
`define DLIM_OFS_MASK_NORMAL 8'h08
`define DLIM_OFS_CLR_NORMAL 8'h0C
`define DLIM_OFS_SWI_CFG 8'h10
`define DLIM_OFS_RAW_FAST 8'h20
`define DLIM_OFS_EN_STAT_FAST 8'h24
`define DLIM_OFS_MASK_FAST 8'h28
`define DLIM_OFS_CLR_FAST 8'h2C
`define DLIM_OFS_EVT_STAT 8'h30
`define DLIM_OFS_EVT_CLR 8'h34
`define DLIM_OFS_EVT_EN 8'h38

// ****************************************************************
// Field layouts and reset values
// ****************************************************************
`define DLIM_SRC_BITS 32'h1FFF_FFFC
`define DLIM_MASK_BITS 32'h1FFF_FFFD
`define DLIM_ALL_BITS 32'hFFFF_FFFF
`define DLIM_FAST_REQ_BITS 32'hFFFF_FFFE
`define DLIM_SWI_BIT 32'h0000_0002
`define DLIM_SUM_MASK 32'h0000_0001
`define DLIM_SUM_BIT 0
`define DLIM_SWI_NORMAL_POS 1
`define DLIM_SWI_FAST_POS 2
`define DLIM_SWI_CFG_BITS 32'h0000_0006
`define DLIM_EVT_BITS 2'h3
`define DLIM_ZERO32 32'h0000_0000
`define DLIM_ZERO2 2'h0
`define DLIM_RST_MASK 32'h0000_0000
`define DLIM_RST_SWI 32'h0000_0000

// ****************************************************************
// AHB-Lite codes
// ****************************************************************
`define DLIM_HRESP_OKAY 1'b0
`define DLIM_ADDR_W 8

`endif

//--- dlim_sync.v
`include "dlim_defines.vh"
`default_nettype none

module dlim_sync (
    input wire clk,
    input wire sys_rst,
    input wire [31:0] async_in,
    output reg [31:0] sync_out
);

    reg [31:0] stage1;
    reg [31:0] stage2;
    reg [31:0] stage3;

    // ****************************************************************
    // Three stage flops and an output flop; a change counts once stages two and three agree
    // ****************************************************************
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= `DLIM_ZERO32;
            stage2 <= `DLIM_ZERO32;
            stage3 <= `DLIM_ZERO32;
            sync_out <= `DLIM_ZERO32;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // Per bit: take stage three where the two agree
            sync_out <= (stage2 & stage3) | (sync_out & (stage2 ^ stage3));
        end
    end

endmodule // dlim_sync

`default_nettype wire

//--- dlim_level.v
`include "dlim_defines.vh"
`default_nettype none

module dlim_level #(
    parameter [31:0] REQ_BITS = 32'hFFFF_FFFF
) (
    input wire clk,
    input wire sys_rst,
    input wire [31:0] src_word,
    input wire software_interrupt,
    input wire [31:0] mask_set,
    input wire [31:0] mask_clr,
    output reg [31:0] raw_status,
    output reg [31:0] enable_mask,
    output reg [31:0] enabled_status,
    output reg request
);

    reg [31:0] next_raw;
    reg [31:0] next_enabled;

    // Raw follows sources live; enabled is raw gated, software bit forced
    always @* begin
        next_raw = (src_word & `DLIM_SRC_BITS) | (src_word & `DLIM_SUM_MASK);
        if (software_interrupt) begin
            next_raw = next_raw | `DLIM_SWI_BIT;
        end
        next_enabled = (next_raw & enable_mask) | (next_raw & `DLIM_SWI_BIT);
    end

    // ****************************************************************
    // Mask, status and request flops
    // ****************************************************************
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            raw_status <= `DLIM_ZERO32;
            enable_mask <= `DLIM_RST_MASK;
            enabled_status <= `DLIM_ZERO32;
            request <= 1'b0;
        end else begin
            raw_status <= next_raw;
            // Clear first, then set; reserved and software bits stay zero
            enable_mask <= ((enable_mask & ~mask_clr) | mask_set) & `DLIM_MASK_BITS;
            enabled_status <= next_enabled;
            request <= |(next_enabled & REQ_BITS);
        end
    end

endmodule // dlim_level

`default_nettype wire

//--- dlim_top.v
// Chosen here: the address map and the AHB-Lite slave port.
`include "dlim_defines.vh"
`default_nettype none

module dlim_top (
    input wire clk,
    input wire sys_rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [31:0] src_req,
    output reg irq_req,
    output reg fast_interrupt_request,
    output reg evt_irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    wire [31:0] src_sync;
    wire [31:0] raw_normal_status;
    wire [31:0] normal_enable_mask;
    wire [31:0] normal_enabled_status;
    wire normal_req;
    wire [31:0] raw_fast_status;
    wire [31:0] fast_enable_mask;
    wire [31:0] fast_enabled_status;
    wire fast_req;
    reg [31:0] software_interrupt_config;
    reg wr_pend;
    reg rd_pend;
    reg [7:0] ph_addr;
    reg [1:0] evt_status;
    reg [1:0] evt_enable;
    reg prev_normal;
    reg prev_fast;
    reg [31:0] normal_set;
    reg [31:0] normal_clr;
    reg [31:0] fast_set;
    reg [31:0] fast_clr;
    reg [1:0] evt_clr;
    reg [1:0] evt_set;
    reg [1:0] next_evt_status;
    reg [31:0] next_hrdata;
    wire addr_take;
    wire [31:0] normal_src;
    wire [31:0] fast_src;

    // Word decode of a captured byte offset
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // Read multiplexer; unmapped and write-only locations read as zero
    function [31:0] read_word;
        input [7:0] addr;
        input [31:0] raw_n;
        input [31:0] sta_n;
        input [31:0] msk_n;
        input [31:0] swi_c;
        input [31:0] raw_f;
        input [31:0] sta_f;
        input [31:0] msk_f;
        input [1:0] e_stat;
        input [1:0] e_en;
        begin
            case (addr)
                `DLIM_OFS_RAW_NORMAL: read_word = raw_n;
                `DLIM_OFS_EN_STAT_NORMAL: read_word = sta_n;
                `DLIM_OFS_MASK_NORMAL: read_word = msk_n;
                `DLIM_OFS_SWI_CFG: read_word = swi_c;
                `DLIM_OFS_RAW_FAST: read_word = raw_f;
                `DLIM_OFS_EN_STAT_FAST: read_word = sta_f;
                `DLIM_OFS_MASK_FAST: read_word = msk_f;
                `DLIM_OFS_EVT_STAT: read_word = {30'h0000_0000, e_stat};
                `DLIM_OFS_EVT_EN: read_word = {30'h0000_0000, e_en};
                default: read_word = `DLIM_ZERO32;
            endcase
        end
    endfunction

    // ****************************************************************
    // Source synchroniser and the two levels
    // ****************************************************************
    // Sources stand outside the clock domain; a request must be sampled
    // high at two successive clock edges to be seen at all
    dlim_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(src_req),
        .sync_out(src_sync)
    );

    // Bit 0 of both raw words carries the fast summary
    assign normal_src = (src_sync & `DLIM_SRC_BITS) | {31'h0000_0000, fast_req};
    assign fast_src = (src_sync & `DLIM_SRC_BITS) | {31'h0000_0000, fast_req};

    dlim_level #(
        .REQ_BITS(`DLIM_ALL_BITS)
    ) u_normal (
        .clk(clk),
        .sys_rst(sys_rst),
        .src_word(normal_src),
        .software_interrupt(software_interrupt_config[`DLIM_SWI_NORMAL_POS]),
        .mask_set(normal_set),
        .mask_clr(normal_clr),
        .raw_status(raw_normal_status),
        .enable_mask(normal_enable_mask),
        .enabled_status(normal_enabled_status),
        .request(normal_req)
    );

    // Fast request ORs bits 31 to 1, so its own summary never loops
    dlim_level #(
        .REQ_BITS(`DLIM_FAST_REQ_BITS)
    ) u_fast (
        .clk(clk),
        .sys_rst(sys_rst),
        .src_word(fast_src),
        .software_interrupt(software_interrupt_config[`DLIM_SWI_FAST_POS]),
        .mask_set(fast_set),
        .mask_clr(fast_clr),
        .raw_status(raw_fast_status),
        .enable_mask(fast_enable_mask),
        .enabled_status(fast_enabled_status),
        .request(fast_req)
    );

    // ****************************************************************
    // AHB-Lite slave: address phase capture
    // ****************************************************************
    assign addr_take = hsel & htrans[1] & hready;

    // Pending flags: a write commits on the next edge, a read waits one
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
        end else if (rd_pend) begin
            // No new address is taken while the read wait stands
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
        end else begin
            wr_pend <= addr_take & hwrite;
            rd_pend <= addr_take & ~hwrite;
        end
    end

    // Offset of the transfer now in its data phase
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ph_addr <= {`DLIM_ADDR_W{1'b0}};
        end else if (addr_take & ~rd_pend) begin
            ph_addr <= haddr[`DLIM_ADDR_W-1:0];
        end
    end

    // Writes finish with no wait; a read holds ready low one cycle so
    // the returned word reflects any write completing just before
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
        end else if (rd_pend) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= ~(addr_take & ~hwrite);
        end
    end

    // ****************************************************************
    // AHB-Lite slave: read data and response
    // ****************************************************************
    // Read multiplexer for the captured offset
    always @* begin
        next_hrdata = read_word(ph_addr, raw_normal_status, normal_enabled_status,
            normal_enable_mask, software_interrupt_config, raw_fast_status,
            fast_enabled_status, fast_enable_mask, evt_status, evt_enable);
    end

    // Read data loads at the end of the wait and holds until the next read
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= `DLIM_ZERO32;
        end else if (rd_pend) begin
            hrdata <= next_hrdata;
        end
    end

    // Response: this slave never reports an error
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hresp <= `DLIM_HRESP_OKAY;
        end else begin
            hresp <= `DLIM_HRESP_OKAY;
        end
    end

    // ****************************************************************
    // Write decode into mask set and clear words
    // ****************************************************************
    always @* begin
        normal_set = `DLIM_ZERO32;
        normal_clr = `DLIM_ZERO32;
        fast_set = `DLIM_ZERO32;
        fast_clr = `DLIM_ZERO32;
        evt_clr = `DLIM_ZERO2;
        if (wr_pend) begin
            if (hit(ph_addr, `DLIM_OFS_MASK_NORMAL)) begin
                normal_set = hwdata;
                fast_clr = hwdata;
            end
            if (hit(ph_addr, `DLIM_OFS_CLR_NORMAL)) begin
                normal_clr = hwdata;
            end
            if (hit(ph_addr, `DLIM_OFS_MASK_FAST)) begin
                fast_set = hwdata;
                normal_clr = hwdata;
            end
            if (hit(ph_addr, `DLIM_OFS_CLR_FAST)) begin
                fast_clr = hwdata;
            end
            if (hit(ph_addr, `DLIM_OFS_EVT_CLR)) begin
                evt_clr = hwdata[1:0];
            end
        end
    end

    // ****************************************************************
    // Software interrupt config and event enable
    // ****************************************************************
    // Software interrupt config; reserved bits 31:3 and 0 stay zero
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            software_interrupt_config <= `DLIM_RST_SWI;
        end else if (wr_pend & hit(ph_addr, `DLIM_OFS_SWI_CFG)) begin
            software_interrupt_config <= hwdata & `DLIM_SWI_CFG_BITS;
        end
    end

    // Event enable, read back in full
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_enable <= `DLIM_ZERO2;
        end else if (wr_pend & hit(ph_addr, `DLIM_OFS_EVT_EN)) begin
            evt_enable <= hwdata[1:0] & `DLIM_EVT_BITS;
        end
    end

    // ****************************************************************
    // Event status: rising edges of the two request lines
    // ****************************************************************
    always @* begin
        evt_set = {fast_req & ~prev_fast, normal_req & ~prev_normal};
        // A new event wins over a clear in the same cycle
        next_evt_status = (evt_status & ~evt_clr) | evt_set;
    end

    // Previous request levels; reset to the idle low level, so no false edge
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_normal <= 1'b0;
            prev_fast <= 1'b0;
        end else begin
            prev_normal <= normal_req;
            prev_fast <= fast_req;
        end
    end

    // Sticky event status and its level interrupt
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_status <= `DLIM_ZERO2;
            evt_irq <= 1'b0;
        end else begin
            evt_status <= next_evt_status;
            evt_irq <= |(next_evt_status & evt_enable);
        end
    end

    // ****************************************************************
    // Request lines to the core
    // ****************************************************************
    // Normal request, one flop after the level's own request
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= normal_req;
        end
    end

    // Fast request, aligned with the normal one
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fast_interrupt_request <= 1'b0;
        end else begin
            fast_interrupt_request <= fast_req;
        end
    end

endmodule // dlim_top

`default_nettype wire

//--- dlim_chk.sv
`include "dlim_defines.vh"
`default_nettype none

module dlim_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] src_req,
    input wire logic irq_req,
    input wire logic fast_interrupt_request,
    input wire logic evt_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Bus and source tracking
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic take;
    logic rd_pend;
    logic wr_seen;
    logic [7:0] rd_ofs;
    logic [26:0] src_prev;
    logic [3:0] stab;
    logic rd_done;
    logic settled;
    assign take = hsel && htrans[1] && hready;
    assign rd_done = rd_pend && hreadyout;
    assign settled = stab > 4'h9;
    // Pending read, any write seen, cycles the sources stood still
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pend <= 1'b0;
            wr_seen <= 1'b0;
            rd_ofs <= 8'h00;
            src_prev <= '0;
            stab <= 4'h0;
        end else begin
            src_prev <= src_req[28:2];
            if (src_req[28:2] != src_prev) stab <= 4'h0;
            else if (stab != 4'hf) stab <= stab + 4'h1;
            if (take && hwrite) wr_seen <= 1'b1;
            if (take && !hwrite) begin
                rd_pend <= 1'b1;
                rd_ofs <= haddr[7:0];
            end else if (hreadyout) begin
                rd_pend <= 1'b0;
            end
        end
    end
    sequence s_rd_take;
        take && !hwrite;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_one_wait: assert property (s_rd_take |=> s_one_wait)
        else $error("read wait is not one cycle");
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write inserted a wait");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_idle_no_irq: assert property (!wr_seen |-> !irq_req && !fast_interrupt_request && !evt_irq)
        else $error("request without any enable");
    a_raw_follows_src: assert property (rd_done && settled
        && (rd_ofs == `DLIM_OFS_RAW_NORMAL || rd_ofs == `DLIM_OFS_RAW_FAST)
        |-> hrdata[28:2] == src_req[28:2] && hrdata[31:29] == 3'h0)
        else $error("raw status differs from sources");
    a_enabled_subset: assert property (rd_done && settled
        && (rd_ofs == `DLIM_OFS_EN_STAT_NORMAL || rd_ofs == `DLIM_OFS_EN_STAT_FAST)
        |-> (hrdata[28:2] & ~src_req[28:2]) == 27'h000_0000)
        else $error("enabled bit without request");
    a_mask_reserved: assert property (rd_done
        && (rd_ofs == `DLIM_OFS_MASK_NORMAL || rd_ofs == `DLIM_OFS_MASK_FAST)
        |-> hrdata[1] == 1'b0 && hrdata[31:29] == 3'h0)
        else $error("reserved mask bit set");
    a_swi_reserved: assert property (rd_done && rd_ofs == `DLIM_OFS_SWI_CFG
        |-> (hrdata & ~`DLIM_SWI_CFG_BITS) == 32'h0000_0000)
        else $error("reserved config bit set");
endmodule // dlim_chk

bind dlim_top dlim_chk i_chk (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hrdata, .hreadyout, .hresp, .src_req, .irq_req, .fast_interrupt_request, .evt_irq);

`default_nettype wire

//--- dlim_src_model.sv
`default_nettype none

module dlim_src_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] req_cmd,
    output var logic [31:0] src_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Peripheral request lines
    // ****************************************************************
    logic [3:0] hold;
    logic [26:0] held;
    logic [4:0] junk;
    // A new request word is taken only after the last one stood 9 cycles
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold <= 4'h0;
            held <= '0;
            junk <= 5'h0a;
        end else begin
            junk <= ~junk;
            if (hold < 4'h8) hold <= hold + 4'h1;
            else if (req_cmd[28:2] != held) begin
                held <= req_cmd[28:2];
                hold <= 4'h0;
            end
        end
    end
    // Lines without a source toggle every cycle
    assign src_req = {junk[4:2], held, junk[1:0]};
endmodule // dlim_src_model

`default_nettype wire

//--- dual_level_interrupt_mask_tb.sv
`include "dlim_defines.vh"
`default_nettype none

module dual_level_interrupt_mask_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals, rows and design
    // ****************************************************************
    logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
    logic irq_req, fast_interrupt_request, evt_irq, fiq_x;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, src_req, req_cmd, rd_val;
    int bad_count, num_checks;
    // Source, normal mask, fast mask, normal enabled, fast enabled
    logic [31:0] rows [5][5] = '{
        '{32'h0000_0010, 32'h0000_0010, 32'h0000_0000, 32'h0000_0010, 32'h0000_0000},
        '{32'h0000_0010, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000},
        '{32'h1000_0004, 32'h1000_0000, 32'h0000_0004, 32'h1000_0000, 32'h0000_0004},
        '{32'h0000_0000, 32'h1fff_fffc, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000},
        '{32'h0400_0000, 32'h0400_0000, 32'h0400_0000, 32'h0000_0000, 32'h0400_0000}};
    logic [7:0] regs [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h28,
        8'h2c, 8'h30, 8'h34, 8'h38, 8'h40};
    assign hready = hreadyout;
    dlim_top i_dut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .src_req, .irq_req, .fast_interrupt_request,
        .evt_irq);
    dlim_src_model i_src (.clk, .sys_rst, .req_cmd, .src_req);
    // Clock of 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd_val = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd_val, exp);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #2_000_000;
        bad_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        complete_run();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        sys_rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata, req_cmd} = '0;
        hsize = 3'b010;
        bad_count = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(`DLIM_OFS_CLR_NORMAL, 32'hffff_ffff);
            wr(`DLIM_OFS_CLR_FAST, 32'hffff_ffff);
            req_cmd <= rows[i][0];
            wr(`DLIM_OFS_MASK_NORMAL, rows[i][1]);
            wr(`DLIM_OFS_MASK_FAST, rows[i][2]);
            repeat (14) @(posedge clk);
            fiq_x = |rows[i][4];
            rd_chk(`DLIM_OFS_RAW_NORMAL, (rows[i][0] & `DLIM_SRC_BITS) | fiq_x);
            rd_chk(`DLIM_OFS_EN_STAT_NORMAL, rows[i][3]);
            rd_chk(`DLIM_OFS_MASK_NORMAL, rows[i][1] & ~rows[i][2]);
            rd_chk(`DLIM_OFS_RAW_FAST, (rows[i][0] & `DLIM_SRC_BITS) | fiq_x);
            rd_chk(`DLIM_OFS_EN_STAT_FAST, rows[i][4]);
            rd_chk(`DLIM_OFS_MASK_FAST, rows[i][2]);
            chk(32'(irq_req), 32'(|rows[i][3]));
            chk(32'(fast_interrupt_request), 32'(fiq_x));
        end
        $display("table cases done");
        req_cmd <= 32'h0000_0000;
        wr(`DLIM_OFS_MASK_NORMAL, 32'h0000_0010);
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        chk(32'(irq_req), 32'h0000_0000);
        foreach (regs[k]) rd_chk(regs[k], 32'h0000_0000);
        $display("reset case done");
        wr(`DLIM_OFS_MASK_NORMAL, 32'h0000_0004);
        wr(`DLIM_OFS_MASK_NORMAL, 32'h0000_0008);
        rd_chk(`DLIM_OFS_MASK_NORMAL, 32'h0000_000c);
        wr(`DLIM_OFS_CLR_NORMAL, 32'h0000_0004);
        rd_chk(`DLIM_OFS_MASK_NORMAL, 32'h0000_0008);
        wr(`DLIM_OFS_MASK_FAST, 32'h0000_0008);
        rd_chk(`DLIM_OFS_MASK_NORMAL, 32'h0000_0000);
        wr(`DLIM_OFS_MASK_NORMAL, 32'h0000_0008);
        rd_chk(`DLIM_OFS_MASK_FAST, 32'h0000_0000);
        wr(`DLIM_OFS_MASK_NORMAL, 32'hffff_ffff);
        rd_chk(`DLIM_OFS_MASK_NORMAL, 32'h1fff_fffd);
        wr(`DLIM_OFS_CLR_NORMAL, 32'hffff_ffff);
        $display("mask case done");
        wr(`DLIM_OFS_EVT_CLR, 32'h0000_0003);
        wr(`DLIM_OFS_EVT_EN, 32'h0000_0001);
        wr(`DLIM_OFS_SWI_CFG, 32'h0000_0002);
        repeat (6) @(posedge clk);
        chk(32'(irq_req), 32'h0000_0001);
        chk(32'(evt_irq), 32'h0000_0001);
        rd_chk(`DLIM_OFS_SWI_CFG, 32'h0000_0002);
        rd_chk(`DLIM_OFS_RAW_NORMAL, 32'h0000_0002);
        rd_chk(`DLIM_OFS_EN_STAT_NORMAL, 32'h0000_0002);
        rd_chk(`DLIM_OFS_EVT_STAT, 32'h0000_0001);
        rd_chk(`DLIM_OFS_EVT_EN, 32'h0000_0001);
        wr(`DLIM_OFS_EVT_EN, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk(32'(evt_irq), 32'h0000_0000);
        wr(`DLIM_OFS_EVT_CLR, 32'h0000_0003);
        rd_chk(`DLIM_OFS_EVT_STAT, 32'h0000_0000);
        wr(`DLIM_OFS_SWI_CFG, 32'hffff_ffff);
        repeat (6) @(posedge clk);
        chk(32'(fast_interrupt_request), 32'h0000_0001);
        rd_chk(`DLIM_OFS_SWI_CFG, 32'h0000_0006);
        rd_chk(`DLIM_OFS_RAW_FAST, 32'h0000_0003);
        rd_chk(`DLIM_OFS_EN_STAT_FAST, 32'h0000_0002);
        rd_chk(`DLIM_OFS_RAW_NORMAL, 32'h0000_0003);
        wr(`DLIM_OFS_SWI_CFG, 32'h0000_0004);
        repeat (6) @(posedge clk);
        chk(32'(irq_req), 32'h0000_0000);
        rd_chk(`DLIM_OFS_RAW_NORMAL, 32'h0000_0001);
        wr(`DLIM_OFS_SWI_CFG, 32'h0000_0000);
        repeat (6) @(posedge clk);
        chk(32'(fast_interrupt_request), 32'h0000_0000);
        rd_chk(`DLIM_OFS_RAW_FAST, 32'h0000_0000);
        $display("software and event case done");
        complete_run();
    end
endmodule // dual_level_interrupt_mask_tb

`default_nettype wire
